// >>> bench/aipc_adc_model.sv
// Converter model feeding the four sample ports and the exponent pins.
`timescale 1ns/1ps
`default_nettype none
module aipc_adc_model (
  input wire logic clk_i,
  input wire logic [aipc_pkg::NPORT-1:0][aipc_pkg::SAMPLE_W-1:0] level_i,
  input wire logic [aipc_pkg::NPORT-1:0][aipc_pkg::EXP_W-1:0] exp_level_i,
  input wire logic [aipc_pkg::NPORT-1:0][aipc_pkg::EXP_W-1:0] dev_exp_i,
  input wire logic [aipc_pkg::NPORT-1:0] dev_oe_n_i,
  output logic [aipc_pkg::NPORT-1:0][aipc_pkg::SAMPLE_W-1:0] adc_data_o,
  output logic [aipc_pkg::NPORT-1:0][aipc_pkg::EXP_W-1:0] exp_pins_o
);
  import aipc_pkg::*;
  initial adc_data_o = '0;
  // Samples launch just after the clock edge, as a real converter does.
  always @(posedge clk_i) adc_data_o <= level_i;
  // The converter drives the pins only while the device is not driving them.
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      exp_pins_o[p] = dev_oe_n_i[p] ? exp_level_i[p] : dev_exp_i[p];
    end
  end
endmodule
`default_nettype wire

// >>> bench/aipc_top_asserts.sv
// Concurrent checks on the ports of the conditioning block.
`timescale 1ns/1ps
`default_nettype none
module aipc_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [aipc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [aipc_pkg::NPORT-1:0][aipc_pkg::SAMPLE_W-1:0] adc_data_i,
  input wire logic [aipc_pkg::NPORT-1:0][aipc_pkg::EXP_W-1:0] gain_exponent_bus_o,
  input wire logic [aipc_pkg::NPORT-1:0] gain_exponent_bus_oe_n_o,
  input wire logic [aipc_pkg::NPORT-1:0][aipc_pkg::SAMPLE_W-1:0] port_data_o,
  input wire logic [aipc_pkg::NPORT-1:0] monitor_event_o
);
  import aipc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ab_cplx;
  logic [4:0] mset1;
  logic [2:0] up;
  logic wr;
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  // Shadows of the pair mode and port 1 monitor setup, and time since reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ab_cplx <= 1'b0;
      mset1 <= 5'h00;
      up <= 3'h0;
    end else begin
      if (up != 3'h4) up <= up + 3'h1;
      if (wr && wb_adr_i == OFF_PAIR_MODE) ab_cplx <= wb_dat_i[MODE_AB];
      if (wr && wb_adr_i == 8'h78) mset1 <= wb_dat_i[4:0];
    end
  end
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence gain0_wr;
    wr && wb_adr_i == PORT_BASE;
  endsequence
  ack_cycle_a: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer timing wrong");
  gain_dir_a: assert property (gain0_wr |=> gain_exponent_bus_oe_n_o[0] == !$past(wb_dat_i[GAIN_EN]))
    else $error("exponent pin direction wrong");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= PORT_END |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  real_pass_a: assert property (up == 3'h4 && !ab_cplx && !$past(ab_cplx, 3)
    |-> port_data_o[1:0] == $past(adc_data_i[1:0], 3)) else $error("real mode altered samples");
  exp_step_a: assert property (!$stable(gain_exponent_bus_o[0])
    |-> gain_exponent_bus_o[0] == $past(gain_exponent_bus_o[0]) + 3'h1
    || gain_exponent_bus_o[0] == $past(gain_exponent_bus_o[0]) - 3'h1) else $error("exponent jumped");
  event_on_a: assert property (monitor_event_o[1] |-> $past(mset1[MON_EN]))
    else $error("event while monitor off");
  event_bad_a: assert property (monitor_event_o[1] |-> $past(mset1[2:1]) != MON_BAD)
    else $error("event on invalid function");
  timer_off_a: assert property (monitor_event_o[1] |-> !$past(mset1[MON_TDIS]))
    else $error("period event with timer off");
endmodule
bind aipc_top aipc_top_asserts u_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .adc_data_i, .gain_exponent_bus_o,
  .gain_exponent_bus_oe_n_o, .port_data_o, .monitor_event_o);
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the ADC input port conditioning block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aipc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [NPORT-1:0][SAMPLE_W-1:0] level = '0, adc, pd;
  logic [NPORT-1:0][EXP_W-1:0] xlev = '0, pins, xo, relin;
  logic [NPORT-1:0] oe_n, ev;
  logic [NTRIM-1:0][SAMPLE_W-1:0] est = '0;
  logic [31:0] msk [7] = '{32'hFF, 32'hFFFFF, 32'hFFFFFF, 32'h0, 32'h3FF, 32'h3FF, 32'h1F};
  logic [15:0] trim [7] = '{16'h0028, 16'h0014, 16'hFFC4, 16'h0800, 16'h0400, 16'h3800, 16'h1000};
  logic [31:0] res [4] = '{32'hC8, 32'h7D0, 32'hA, 32'hA};
  int fails = 0, samples_checked = 0, cyc_n = 0, n, t1;
  logic [31:0] e;
  aipc_top dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack), .adc_data_i(adc),
    .gain_exponent_bus_i(pins), .gain_exponent_bus_o(xo), .gain_exponent_bus_oe_n_o(oe_n),
    .est_trim_i(est), .port_data_o(pd), .relin_exponent_o(relin), .monitor_event_o(ev));
  aipc_adc_model adc_m (.clk_i, .level_i(level), .exp_level_i(xlev), .dev_exp_i(xo),
    .dev_oe_n_i(oe_n), .adc_data_o(adc), .exp_pins_o(pins));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
    samples_checked++;
    if (seen !== exp_v) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp_v);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // One classic cycle; the request is held until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    check(rdat, x);
  endtask
  task automatic final_report;
    $display("compares %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    tick(10);
    rst_i <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      rd(8'hA0 + 8'(4 * k), 32'h0);
      bus(1'b1, 8'hA0 + 8'(4 * k), 32'hFFFFFFFF);
      rd(8'hA0 + 8'(4 * k), msk[k]);
      rd(8'h80 + 8'(4 * k), 32'h0);
      bus(1'b1, 8'hA0 + 8'(4 * k), 32'h0);
    end
    bus(1'b1, 8'h28, 32'hFFFFFFFF);
    rd(8'h28, 32'h0);
    rd(8'hC4, 32'h0);
    $display("register map done");
    level <= '{16'hFED4, 16'hFE0C, 16'd200, 16'd1000};
    for (int k = 0; k < 7; k++) bus(1'b1, 8'(4 * k), {16'h0, trim[k]});
    rd(8'h14, 32'h3800);
    bus(1'b1, OFF_PAIR_MODE, 32'h3);
    tick(5);
    check(pd[0], 32'h0410);
    check(pd[1], 32'h00B4);
    check(pd[2], 32'hFE34);
    check(pd[3], 32'hFE98);
    est[1] <= 16'd12;
    bus(1'b1, OFF_CD_CTL, 32'h7);
    tick(4);
    check(pd[2], 32'hFE00);
    check(pd[3], 32'hFED4);
    bus(1'b1, OFF_PAIR_MODE, 32'h0);
    tick(4);
    check(pd[0], 32'h03E8);
    check(pd[2], 32'hFE0C);
    $display("iq correction done");
    bus(1'b1, 8'h50, 32'd100);
    bus(1'b1, 8'h54, 32'd50);
    bus(1'b1, 8'h44, 32'd20);
    bus(1'b1, 8'h40, 32'h9);
    tick(1);
    check(oe_n[0], 32'h0);
    n = 0;
    while (xo[0] !== 3'h7 && n < 40) begin
      tick(1);
      n++;
    end
    check(xo[0], 32'h7);
    level[0] <= 16'd75;
    tick(40);
    check(xo[0], 32'h7);
    level[0] <= 16'hFFF6;
    n = 0;
    while (xo[0] === 3'h7 && n < 60) begin
      tick(1);
      n++;
    end
    check({31'h0, n >= 20 && n <= 26}, 32'h1);
    n = 0;
    while (relin[0] !== xo[0] && n < 10) begin
      tick(1);
      n++;
    end
    check(n, 32'd4);
    xlev[1] <= 3'h5;
    tick(6);
    check(relin[1], 32'h5);
    check(oe_n[1], 32'h1);
    $display("gain control done");
    bus(1'b1, 8'h68, 32'd10);
    bus(1'b1, 8'h70, 32'd100);
    for (int f = 0; f < 5; f++) begin
      bus(1'b1, 8'h78, f < 4 ? 32'(1 + 2 * f) : 32'h0);
      tick(15);
      e = 0;
      repeat (40) begin
        tick(1);
        e += 32'(ev[1]);
      end
      check(e, f % 4 == 3 || f == 4 ? 32'd0 : 32'd4);
      if (f < 4) rd(8'h6C, res[f]);
    end
    bus(1'b1, 8'h78, 32'h1D);
    bus(1'b0, 8'h6C, 32'h0);
    t1 = cyc_n;
    tick(20);
    bus(1'b0, 8'h6C, 32'h0);
    t1 = cyc_n - t1;
    tick(20);
    bus(1'b0, 8'h6C, 32'h0);
    check({31'h0, rdat + 1 >= t1 && rdat <= t1 + 1}, 32'h1);
    $display("power monitor done");
    final_report;
  end
  initial begin
    tick(20000);
    fails++;
    final_report;
  end
endmodule
`default_nettype wire

// >>> hw/aipc_iq_corr.sv
// DC, phase and amplitude correction of one complex sample pair.
`timescale 1ns/1ps
`default_nettype none
module aipc_iq_corr (
  input wire logic clk_i,
  input wire logic rst_i,
  aipc_iq_if.corr iq
);
  import aipc_pkg::*;
  logic signed [SAMPLE_W-1:0] i_dc;
  logic signed [SAMPLE_W-1:0] q_dc;
  logic signed [SAMPLE_W+TRIM_W-1:0] ph_prod;
  logic signed [SAMPLE_W+TRIM_W-1:0] am_prod;

  // Phase and amplitude trims are signed fractions with IQ_FRAC fraction bits; DC trims are whole sample offsets.
  assign i_dc = $signed(iq.i_raw) - $signed(iq.dc_i);
  assign q_dc = $signed(iq.q_raw) - $signed(iq.dc_q);
  assign ph_prod = q_dc * $signed(iq.phase);
  assign am_prod = q_dc * $signed(iq.amp);

  // Real mode passes the raw samples and ignores every trim.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iq.i_out <= '0;
      iq.q_out <= '0;
    end else if (iq.cplx) begin
      iq.i_out <= SAMPLE_W'(i_dc + ph_prod[IQ_FRAC +: SAMPLE_W]);
      iq.q_out <= SAMPLE_W'(q_dc + am_prod[IQ_FRAC +: SAMPLE_W]);
    end else begin
      iq.i_out <= iq.i_raw;
      iq.q_out <= iq.q_raw;
    end
  end
endmodule
`default_nettype wire

// >>> hw/aipc_relin_delay.sv
// Programmable pipeline delay of the exponent used for relinearization.
`timescale 1ns/1ps
`default_nettype none
module aipc_relin_delay (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [aipc_pkg::EXP_W-1:0] exp_i,
  input wire logic [aipc_pkg::RELIN_W-1:0] delay_i,
  output logic [aipc_pkg::EXP_W-1:0] exp_o
);
  import aipc_pkg::*;
  logic [EXP_W-1:0] hist [RELIN_DEPTH];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist[0] <= '0;
    end else begin
      hist[0] <= exp_i;
    end
  end

  for (genvar k = 1; k < RELIN_DEPTH; k++) begin : g_pipe
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        hist[k] <= '0;
      end else begin
        hist[k] <= hist[k-1];
      end
    end
  end

  // A delay of zero applies the exponent in the cycle it is put out.
  assign exp_o = (delay_i == '0) ? exp_i : hist[RELIN_W'(delay_i - 6'h01)];
endmodule
`default_nettype wire

// >>> hw/aipc_top.sv
// ADC input port conditioning: IQ correction, gain control and power monitor.
`timescale 1ns/1ps
`default_nettype none
module aipc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [aipc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [aipc_pkg::NPORT-1:0][aipc_pkg::SAMPLE_W-1:0] adc_data_i,
  input wire logic [aipc_pkg::NPORT-1:0][aipc_pkg::EXP_W-1:0] gain_exponent_bus_i,
  output logic [aipc_pkg::NPORT-1:0][aipc_pkg::EXP_W-1:0] gain_exponent_bus_o,
  output logic [aipc_pkg::NPORT-1:0] gain_exponent_bus_oe_n_o,
  input wire logic [aipc_pkg::NTRIM-1:0][aipc_pkg::SAMPLE_W-1:0] est_trim_i,
  output logic [aipc_pkg::NPORT-1:0][aipc_pkg::SAMPLE_W-1:0] port_data_o,
  output logic [aipc_pkg::NPORT-1:0][aipc_pkg::EXP_W-1:0] relin_exponent_o,
  output logic [aipc_pkg::NPORT-1:0] monitor_event_o
);
  import aipc_pkg::*;
  logic [SAMPLE_W-1:0] trim [NTRIM];
  logic [2:0] ab_ctl;
  logic [2:0] cd_ctl;
  logic [1:0] pair_mode;
  logic [GAIN_W-1:0] gain_setup [NPORT];
  logic [DWELL_W-1:0] dwell_time [NPORT];
  logic [MON_W-1:0] mon_period [NPORT];
  logic [THR_W-1:0] high_limit [NPORT];
  logic [THR_W-1:0] low_limit [NPORT];
  logic [MSETUP_W-1:0] mon_setup [NPORT];
  logic [MON_W-1:0] mon_result [NPORT];
  logic [SAMPLE_W-1:0] adc_meta [NPORT];
  logic [SAMPLE_W-1:0] adc_sync [NPORT];
  logic [EXP_W-1:0] exp_meta [NPORT];
  logic [EXP_W-1:0] exp_sync [NPORT];
  logic [EXP_W-1:0] exp_drive [NPORT];
  logic [EXP_W-1:0] relin_exp [NPORT];
  logic mon_event [NPORT];
  logic [NPORT-1:0] result_read;
  logic bus_req;
  logic wr_go;
  logic rd_go;
  logic in_port;
  logic [7:0] padr;
  logic [1:0] pidx;
  logic [4:0] poff;
  logic [31:0] next_rdata;
  logic [31:0] wval;
  // Register bus slave: one wait state, ack stands for exactly one cycle.
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_go = bus_req & wb_we_i & wb_ack_o;
  assign rd_go = bus_req & ~wb_we_i & wb_ack_o;
  assign padr = wb_adr_i - PORT_BASE;
  assign in_port = (wb_adr_i >= PORT_BASE) && (wb_adr_i < PORT_END);
  assign pidx = padr[6:5];
  assign poff = padr[4:0];
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req & ~wb_ack_o & ~wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end
  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    next_rdata = '0;
    if (wb_adr_i < OFF_TRIM_END) begin
      next_rdata = 32'(trim[wb_adr_i[4:2]]);
    end else if (wb_adr_i == OFF_AB_CTL) begin
      next_rdata = 32'(ab_ctl);
    end else if (wb_adr_i == OFF_CD_CTL) begin
      next_rdata = 32'(cd_ctl);
    end else if (wb_adr_i == OFF_PAIR_MODE) begin
      next_rdata = 32'(pair_mode);
    end else if (in_port) begin
      case (poff)
        P_GAIN: next_rdata = 32'(gain_setup[pidx]);
        P_DWELL: next_rdata = 32'(dwell_time[pidx]);
        P_PERIOD: next_rdata = 32'(mon_period[pidx]);
        P_RESULT: next_rdata = 32'(mon_result[pidx]);
        P_HIGH: next_rdata = 32'(high_limit[pidx]);
        P_LOW: next_rdata = 32'(low_limit[pidx]);
        P_MSETUP: next_rdata = 32'(mon_setup[pidx]);
        default: next_rdata = '0;
      endcase
    end
  end
  assign wval = merge_lanes(next_rdata, wb_dat_i, wb_sel_i);
  // Pair-level trims and correction controls.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int t = 0; t < NTRIM; t++) begin
        trim[t] <= TRIM_RST;
      end
      ab_ctl <= CTL_RST;
      cd_ctl <= CTL_RST;
      pair_mode <= MODE_RST;
    end else if (wr_go) begin
      if (wb_adr_i < OFF_TRIM_END) begin
        trim[wb_adr_i[4:2]] <= wval[SAMPLE_W-1:0];
      end else if (wb_adr_i == OFF_AB_CTL) begin
        ab_ctl <= wval[2:0];
      end else if (wb_adr_i == OFF_CD_CTL) begin
        cd_ctl <= wval[2:0];
      end else if (wb_adr_i == OFF_PAIR_MODE) begin
        pair_mode <= wval[1:0];
      end
    end
  end
  // Per-port register sets, selected by the port index of the address.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < NPORT; p++) begin
        gain_setup[p] <= GAIN_RST;
        dwell_time[p] <= DWELL_RST;
        mon_period[p] <= PERIOD_RST;
        high_limit[p] <= THR_RST;
        low_limit[p] <= THR_RST;
        mon_setup[p] <= MSETUP_RST;
      end
    end else if (wr_go && in_port) begin
      case (poff)
        P_GAIN: gain_setup[pidx] <= wval[GAIN_W-1:0];
        P_DWELL: dwell_time[pidx] <= wval[DWELL_W-1:0];
        P_PERIOD: mon_period[pidx] <= wval[MON_W-1:0];
        P_HIGH: high_limit[pidx] <= wval[THR_W-1:0];
        P_LOW: low_limit[pidx] <= wval[THR_W-1:0];
        P_MSETUP: mon_setup[pidx] <= wval[MSETUP_W-1:0];
        default: ;
      endcase
    end
  end
  // Complex pair correction; the estimator supplies a trim when its enable is set.
  function automatic logic [SAMPLE_W-1:0] pick_trim(input logic en, input logic [SAMPLE_W-1:0] reg_v,
                                                    input logic [SAMPLE_W-1:0] est_v);
    return en ? est_v : reg_v;
  endfunction
  aipc_iq_if ab_if ();
  aipc_iq_if cd_if ();
  assign ab_if.i_raw = adc_sync[0];
  assign ab_if.q_raw = adc_sync[1];
  assign ab_if.dc_i = TRIM_RST;
  assign ab_if.dc_q = pick_trim(ab_ctl[IQ_DC_EN], trim[T_AB_DCQ], est_trim_i[T_AB_DCQ]);
  assign ab_if.phase = TRIM_W'(pick_trim(ab_ctl[IQ_PH_EN], trim[T_AB_PH], est_trim_i[T_AB_PH]));
  assign ab_if.amp = TRIM_W'(pick_trim(ab_ctl[IQ_AMP_EN], trim[T_AB_AMP], est_trim_i[T_AB_AMP]));
  assign ab_if.cplx = pair_mode[MODE_AB];
  assign cd_if.i_raw = adc_sync[2];
  assign cd_if.q_raw = adc_sync[3];
  assign cd_if.dc_i = pick_trim(cd_ctl[IQ_DC_EN], trim[T_CD_DCI], est_trim_i[T_CD_DCI]);
  assign cd_if.dc_q = pick_trim(cd_ctl[IQ_DC_EN], trim[T_CD_DCQ], est_trim_i[T_CD_DCQ]);
  assign cd_if.phase = TRIM_W'(pick_trim(cd_ctl[IQ_PH_EN], trim[T_CD_PH], est_trim_i[T_CD_PH]));
  assign cd_if.amp = TRIM_W'(pick_trim(cd_ctl[IQ_AMP_EN], trim[T_CD_AMP], est_trim_i[T_CD_AMP]));
  assign cd_if.cplx = pair_mode[MODE_CD];
  aipc_iq_corr u_ab_corr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .iq(ab_if.corr)
  );
  aipc_iq_corr u_cd_corr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .iq(cd_if.corr)
  );
  assign port_data_o = {cd_if.q_out, cd_if.i_out, ab_if.q_out, ab_if.i_out};
  // Per-port gain control and power monitoring.
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [SAMPLE_W-1:0] mag;
    logic above;
    logic below;
    logic gain_on;
    logic [EXP_W-1:0] exp_cur;
    aipc_gain_state_t gstate;
    logic [DWELL_W-1:0] dwell_cnt;
    logic mon_on;
    logic timer_off;
    logic clr_on_read;
    aipc_mon_fn_t fn;
    logic fn_ok;
    logic [MON_W-1:0] pcnt;
    logic period_end;
    logic [MON_W-1:0] acc;
    logic [MON_W-1:0] next_acc;
    logic [MON_W:0] sum;
    assign result_read[p] = rd_go && in_port && (poff == P_RESULT) && (pidx == 2'(p));
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        adc_meta[p] <= '0;
        adc_sync[p] <= '0;
        exp_meta[p] <= '0;
        exp_sync[p] <= '0;
      end else begin
        adc_meta[p] <= adc_data_i[p];
        adc_sync[p] <= adc_meta[p];
        exp_meta[p] <= gain_exponent_bus_i[p];
        exp_sync[p] <= exp_meta[p];
      end
    end
    assign mag = adc_sync[p][SAMPLE_W-1] ? SAMPLE_W'(-adc_sync[p]) : adc_sync[p];
    assign above = mag > SAMPLE_W'(high_limit[p]);
    assign below = mag < SAMPLE_W'(low_limit[p]);
    assign gain_on = gain_setup[p][GAIN_EN];

    // Raise the exponent on a loud sample; lower it only after a full quiet dwell.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        gstate <= GS_IDLE;
        dwell_cnt <= '0;
        exp_drive[p] <= '0;
      end else if (!gain_on) begin
        gstate <= GS_IDLE;
        dwell_cnt <= '0;
      end else if (above) begin
        gstate <= GS_IDLE;
        dwell_cnt <= '0;
        if (exp_drive[p] != '1) begin
          exp_drive[p] <= exp_drive[p] + 3'h1;
        end
      end else begin
        case (gstate)
          GS_IDLE: begin
            if (below) begin
              dwell_cnt <= dwell_time[p];
              gstate <= GS_DWELL;
            end
          end
          GS_DWELL: begin
            if (dwell_cnt == '0) begin
              gstate <= GS_IDLE;
              if (exp_drive[p] != '0) begin
                exp_drive[p] <= exp_drive[p] - 3'h1;
              end
            end else begin
              dwell_cnt <= dwell_cnt - 20'h00001;
            end
          end
          default: gstate <= GS_IDLE;
        endcase
      end
    end

    assign exp_cur = gain_on ? exp_drive[p] : exp_sync[p];

    aipc_relin_delay u_relin (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .exp_i(exp_cur),
      .delay_i(gain_setup[p][RELIN_LSB +: RELIN_W]),
      .exp_o(relin_exp[p])
    );

    assign mon_on = mon_setup[p][MON_EN];
    assign timer_off = mon_setup[p][MON_TDIS];
    assign clr_on_read = mon_setup[p][MON_COR];
    assign fn = aipc_mon_fn_t'(mon_setup[p][MON_FN_LSB +: 2]);
    assign fn_ok = (fn != MON_BAD);
    assign period_end = ({1'b0, pcnt} + 25'h0000001) >= {1'b0, mon_period[p]};
    assign sum = {1'b0, acc} + (MON_W + 1)'(mag);

    always_comb begin
      next_acc = acc;
      case (fn)
        MON_PEAK: begin
          if (above && (MON_W'(mag) > acc)) begin
            next_acc = MON_W'(mag);
          end
        end
        MON_MEAN: next_acc = sum[MON_W] ? '1 : sum[MON_W-1:0];
        MON_CROSS: begin
          if (above && (acc != '1)) begin
            next_acc = acc + 24'h000001;
          end
        end
        default: next_acc = acc;
      endcase
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pcnt <= '0;
        acc <= '0;
        mon_result[p] <= '0;
        mon_event[p] <= 1'b0;
      end else if (!mon_on) begin
        pcnt <= '0;
        acc <= '0;
        mon_event[p] <= 1'b0;
      end else if (!timer_off) begin
        mon_event[p] <= 1'b0;
        if (period_end) begin
          pcnt <= '0;
          acc <= '0;
          if (fn_ok) begin
            mon_result[p] <= next_acc;
            mon_event[p] <= 1'b1;
          end
        end else begin
          pcnt <= pcnt + 24'h000001;
          acc <= next_acc;
        end
      end else begin
        pcnt <= '0;
        mon_event[p] <= 1'b0;
        if (result_read[p] && fn_ok) begin
          mon_result[p] <= next_acc;
          acc <= clr_on_read ? '0 : next_acc;
        end else begin
          acc <= next_acc;
        end
      end
    end
  end

  assign gain_exponent_bus_o = {exp_drive[3], exp_drive[2], exp_drive[1], exp_drive[0]};
  assign gain_exponent_bus_oe_n_o = {~gain_setup[3][GAIN_EN], ~gain_setup[2][GAIN_EN],
                                     ~gain_setup[1][GAIN_EN], ~gain_setup[0][GAIN_EN]};
  assign relin_exponent_o = {relin_exp[3], relin_exp[2], relin_exp[1], relin_exp[0]};
  assign monitor_event_o = {mon_event[3], mon_event[2], mon_event[1], mon_event[0]};
endmodule
`default_nettype wire

// >>> pkg/aipc_iq_if.sv
// Interface carrying one complex pair between the top and its correction stage.
`timescale 1ns/1ps
`default_nettype none
interface aipc_iq_if;
  import aipc_pkg::*;
  logic [SAMPLE_W-1:0] i_raw;
  logic [SAMPLE_W-1:0] q_raw;
  logic [SAMPLE_W-1:0] dc_i;
  logic [SAMPLE_W-1:0] dc_q;
  logic [TRIM_W-1:0] phase;
  logic [TRIM_W-1:0] amp;
  logic cplx;
  logic [SAMPLE_W-1:0] i_out;
  logic [SAMPLE_W-1:0] q_out;
  modport ctrl (output i_raw, q_raw, dc_i, dc_q, phase, amp, cplx, input i_out, q_out);
  modport corr (input i_raw, q_raw, dc_i, dc_q, phase, amp, cplx, output i_out, q_out);
endinterface
`default_nettype wire

// >>> pkg/aipc_pkg.sv
// Shared constants and types for the ADC input port conditioning block.
`default_nettype none
package aipc_pkg;
  localparam int NPORT = 4;
  localparam int SAMPLE_W = 16;
  localparam int EXP_W = 3;
  localparam int TRIM_W = 14;
  localparam int IQ_FRAC = 13;
  localparam int NTRIM = 7;
  localparam int ADR_W = 8;
  localparam int RELIN_W = 6;
  localparam int RELIN_DEPTH = 64;
  localparam int DWELL_W = 20;
  localparam int MON_W = 24;
  localparam int THR_W = 10;
  localparam int GAIN_W = 8;
  localparam int MSETUP_W = 5;
  // Trim register indices; the byte offset of each is four times its index.
  localparam logic [2:0] T_AB_DCQ = 3'h0;
  localparam logic [2:0] T_CD_DCI = 3'h1;
  localparam logic [2:0] T_CD_DCQ = 3'h2;
  localparam logic [2:0] T_AB_PH = 3'h3;
  localparam logic [2:0] T_AB_AMP = 3'h4;
  localparam logic [2:0] T_CD_PH = 3'h5;
  localparam logic [2:0] T_CD_AMP = 3'h6;
  localparam logic [7:0] OFF_TRIM_END = 8'h1C;
  localparam logic [7:0] OFF_AB_CTL = 8'h1C;
  localparam logic [7:0] OFF_CD_CTL = 8'h20;
  localparam logic [7:0] OFF_PAIR_MODE = 8'h24;
  localparam logic [7:0] PORT_BASE = 8'h40;
  localparam logic [7:0] PORT_END = 8'hC0;
  localparam logic [4:0] P_GAIN = 5'h00;
  localparam logic [4:0] P_DWELL = 5'h04;
  localparam logic [4:0] P_PERIOD = 5'h08;
  localparam logic [4:0] P_RESULT = 5'h0C;
  localparam logic [4:0] P_HIGH = 5'h10;
  localparam logic [4:0] P_LOW = 5'h14;
  localparam logic [4:0] P_MSETUP = 5'h18;
  localparam int IQ_DC_EN = 0;
  localparam int IQ_PH_EN = 1;
  localparam int IQ_AMP_EN = 2;
  localparam int MODE_AB = 0;
  localparam int MODE_CD = 1;
  localparam int GAIN_EN = 0;
  localparam int RELIN_LSB = 1;
  localparam int MON_EN = 0;
  localparam int MON_FN_LSB = 1;
  localparam int MON_COR = 3;
  localparam int MON_TDIS = 4;
  localparam logic [15:0] TRIM_RST = 16'h0000;
  localparam logic [2:0] CTL_RST = 3'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [19:0] DWELL_RST = 20'h00000;
  localparam logic [23:0] PERIOD_RST = 24'h000000;
  localparam logic [9:0] THR_RST = 10'h000;
  localparam logic [4:0] MSETUP_RST = 5'h00;
  typedef enum logic [1:0] {MON_PEAK = 2'h0, MON_MEAN = 2'h1, MON_CROSS = 2'h2, MON_BAD = 2'h3} aipc_mon_fn_t;
  typedef enum logic [1:0] {GS_IDLE = 2'h1, GS_DWELL = 2'h2} aipc_gain_state_t;
endpackage
`default_nettype wire
